// [src/csi_core.sv]
// character string interpreter: unpacks codes, offers them to the glyph
// generator, else forms dispatch addresses for the channel controller
// assumes the controller, memory and generator share core_clk
`timescale 1ns/1ps
`default_nettype none
`include "csi_cfg.svh"

module csi_core (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // parameter register port
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [3:0]            reg_index,
    input  wire csi_pkg::csi_word_t    reg_wdata,
    output logic                       reg_rvalid,
    output csi_pkg::csi_word_t         reg_rdata,
    // controller command and status
    input  wire logic                  do_char,
    input  wire logic                  count_load,
    input  wire csi_pkg::csi_addr_t    count_value,
    input  wire csi_pkg::csi_addr_t    read_pointer,
    input  wire logic                  sub_return,
    input  wire logic                  prog_stop,
    output logic                       repeat_mode,
    output csi_pkg::csi_addr_t         read_count,
    output logic                       word_taken,
    output logic                       dispatch_load,
    output csi_pkg::csi_addr_t         dispatch_pointer,
    // memory read port
    output logic                       mem_req,
    output csi_pkg::csi_addr_t         mem_addr,
    input  wire logic                  mem_gnt,
    input  wire logic                  mem_rvalid,
    output logic                       mem_rready,
    input  wire csi_pkg::csi_word_t    mem_rdata,
    // glyph generator
    input  wire logic                  gen_present,
    output logic                       gen_valid,
    output logic [7:0]                 gen_code,
    input  wire logic                  gen_hit,
    output logic                       gen_enabled
);
    import csi_pkg::*;

    // ****************************************************************
    // functions
    // ****************************************************************

    // 36 minus width: refill offset
    function automatic logic [5:0] csi_refill(input logic [3:0] wid);
        csi_refill = `CSI_WORD_BITS - {2'b00, wid};
    endfunction : csi_refill

    // offset minus width, bit 6 marks a negative result
    function automatic logic [6:0] csi_step(input logic [5:0] ofs,
                                            input logic [3:0] wid);
        csi_step = {1'b0, ofs} - {3'b000, wid};
    endfunction : csi_step

    // ****************************************************************
    // state
    // ****************************************************************
    csi_state_e       state_q;
    csi_state_e       state_d;
    csi_word_t        packed_q;
    logic [5:0]       ofs_q;
    logic [3:0]       wid_q;
    logic             gen_on_q;
    csi_addr_t        org_q;
    csi_addr_t        count_q;
    csi_addr_t        disp_q;
    logic             disp_ld_q;
    csi_word_t        rdata_q;
    logic             rvalid_q;

    // ****************************************************************
    // decode and datapath wires
    // ****************************************************************
    logic             wr_packed;
    logic             wr_format;
    logic             wr_upcoming;
    logic             load_en;
    logic [1:0]       pair;
    csi_word_t        shifted;
    logic [14:0]      code_full;
    logic [14:0]      wid_mask;
    logic [7:0]       code;
    logic [6:0]       ofs_next;
    logic             ofs_neg;
    logic             ofs_bad;
    csi_addr_t        count_inc;
    csi_addr_t        disp_addr;
    logic             fifo_valid;
    logic             fifo_ready;
    csi_word_t        fifo_data;
    logic             gen_take;
    csi_word_t        format_view;

    // register decode
    assign wr_packed   = reg_wr & (reg_index == `CSI_REG_PACKED);
    assign wr_format   = reg_wr & (reg_index == `CSI_REG_FORMAT);
    assign wr_upcoming = reg_wr & (reg_index == `CSI_REG_UPCOMING);
    assign load_en     = reg_wdata[`CSI_LDEN_BIT];
    assign pair        = {reg_wdata[`CSI_GEN_J], reg_wdata[`CSI_GEN_K]};

    // code extraction: field ending offset bits from the right
    assign shifted   = packed_q >> ofs_q;
    assign wid_mask  = ~(15'h7FFF << wid_q);
    assign code_full = shifted[14:0] & wid_mask;
    assign code      = code_full[7:0];
    assign ofs_next  = csi_step(ofs_q, wid_q);
    assign ofs_neg   = ofs_next[6];
    assign ofs_bad   = (ofs_q > `CSI_OFS_LIMIT);
    assign count_inc = count_q + 18'h00001;

    // dispatch address: origin plus low code byte only
    assign disp_addr = org_q + {10'h000, code};

    // generator offer and acceptance
    assign gen_valid   = (state_q == CSI_OFFER) & gen_on_q & gen_present;
    assign gen_code    = code;
    assign gen_take    = gen_valid & gen_hit;
    assign gen_enabled = gen_on_q;

    // memory request at the controller read pointer
    assign mem_req    = (state_q == CSI_FETCH);
    assign mem_addr   = read_pointer;
    assign word_taken = mem_req & mem_gnt;

    // controller facing outputs
    assign repeat_mode      = (state_q != CSI_IDLE);
    assign read_count       = count_q;
    assign dispatch_pointer = disp_q;
    assign dispatch_load    = disp_ld_q;
    assign reg_rdata        = rdata_q;
    assign reg_rvalid       = rvalid_q;

    // format register as seen by store and sink
    always_comb begin
        format_view = '0;
        format_view[`CSI_OFS_HI:`CSI_OFS_LO] = ofs_q;
        format_view[`CSI_WID_HI:`CSI_WID_LO] = wid_q;
        format_view[`CSI_LDEN_BIT] = 1'b1;
        format_view[`CSI_ORG_HI:`CSI_ORG_LO] = org_q;
    end

    // ****************************************************************
    // word buffer between memory and the interpreter
    // ****************************************************************
    csi_fifo #(
        .WIDTH (`CSI_WORD_W),
        .DEPTH (`CSI_FIFO_D)
    ) u_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (mem_rvalid),
        .in_ready  (mem_rready),
        .in_data   (mem_rdata),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );
    assign fifo_ready = (state_q == CSI_WAIT);

    // ****************************************************************
    // sequencer
    // ****************************************************************

    // next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CSI_IDLE: begin
                if (do_char) begin
                    state_d = CSI_FETCH;
                end
            end
            CSI_FETCH: begin
                if (mem_gnt) begin
                    state_d = CSI_WAIT;
                end
            end
            CSI_WAIT: begin
                if (fifo_valid) begin
                    state_d = CSI_OFFER;
                end
            end
            CSI_OFFER: begin
                state_d = gen_take ? CSI_STEP : CSI_CALL;
            end
            CSI_CALL: begin
                if (prog_stop) begin
                    state_d = CSI_IDLE;
                end else if (sub_return) begin
                    state_d = CSI_STEP;
                end
            end
            CSI_STEP: begin
                if (!count_inc[17]) begin
                    state_d = CSI_IDLE;
                end else if (ofs_neg) begin
                    state_d = CSI_FETCH;
                end else begin
                    state_d = CSI_OFFER;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= CSI_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // packed word register
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            packed_q <= '0;
        end else if (state_q == CSI_WAIT && fifo_valid) begin
            packed_q <= fifo_data;
        end else if (wr_packed) begin
            packed_q <= reg_wdata;
        end
    end

    // ****************************************************************
    // format register: offset, width, generator switch, origin
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ofs_q <= '0;
            wid_q <= '0;
        end else if (state_q == CSI_WAIT && fifo_valid && ofs_bad) begin
            ofs_q <= csi_refill(wid_q);
        end else if (state_q == CSI_STEP && ofs_neg) begin
            ofs_q <= csi_refill(wid_q);
        end else if (state_q == CSI_STEP) begin
            ofs_q <= ofs_next[5:0];
        end else if (wr_upcoming) begin
            ofs_q <= ofs_neg ? csi_refill(wid_q) : ofs_next[5:0];
        end else if (wr_format && load_en) begin
            ofs_q <= reg_wdata[`CSI_OFS_HI:`CSI_OFS_LO];
            wid_q <= reg_wdata[`CSI_WID_HI:`CSI_WID_LO];
        end
    end

    // generator switch and table origin
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gen_on_q <= 1'b0;
            org_q    <= '0;
        end else if (wr_format) begin
            org_q <= reg_wdata[`CSI_ORG_HI:`CSI_ORG_LO];
            unique case (pair)
                2'b00: gen_on_q <= gen_on_q;
                2'b01: gen_on_q <= 1'b0;
                2'b10: gen_on_q <= 1'b1;
                2'b11: gen_on_q <= ~gen_on_q;
            endcase
        end
    end

    // ****************************************************************
    // read count and dispatch pointer
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            count_q <= '0;
        end else if (state_q == CSI_STEP) begin
            count_q <= count_inc;
        end else if (count_load) begin
            count_q <= count_value;
        end
    end

    // dispatch address is held, never incremented
    always_ff @(posedge core_clk) begin
        if (srst) begin
            disp_q    <= '0;
            disp_ld_q <= 1'b0;
        end else begin
            disp_ld_q <= (state_q == CSI_OFFER) & ~gen_take;
            if (state_q == CSI_OFFER && !gen_take) begin
                disp_q <= disp_addr;
            end
        end
    end

    // ****************************************************************
    // register read answer, one cycle after the strobe
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                unique case (reg_index)
                    `CSI_REG_PACKED:   rdata_q <= packed_q;
                    `CSI_REG_FORMAT:   rdata_q <= format_view;
                    `CSI_REG_UPCOMING: rdata_q <= {28'h0000000, code};
                    default:           rdata_q <= '0;
                endcase
            end
        end
    end

endmodule : csi_core
`default_nettype wire

// [src/csi_cfg.svh]
// constants of the character string interpreter: offsets, fields, counts
// assumes the includer uses the macros only; holds definitions only
`ifndef CSI_CFG_SVH
`define CSI_CFG_SVH

// ****************************************************************
// register indices on the parameter register port
// ****************************************************************
`define CSI_REG_PACKED   4'h0
`define CSI_REG_FORMAT   4'h1
`define CSI_REG_UPCOMING 4'hF

// ****************************************************************
// widths
// ****************************************************************
`define CSI_WORD_W  36
`define CSI_ADDR_W  18
`define CSI_CODE_W  8
`define CSI_FIFO_D  16

// ****************************************************************
// format register fields (bit 0 = least significant)
// ****************************************************************
`define CSI_OFS_HI   35
`define CSI_OFS_LO   30
`define CSI_WID_HI   27
`define CSI_WID_LO   24
`define CSI_LDEN_BIT 21
`define CSI_GEN_J    20
`define CSI_GEN_K    19
`define CSI_ORG_HI   17
`define CSI_ORG_LO   0

// ****************************************************************
// offset arithmetic
// ****************************************************************
`define CSI_WORD_BITS 6'h24
`define CSI_OFS_LIMIT 6'h27
`define CSI_MAX_WIDTH 4'hF

`endif

// [src/csi_pkg.sv]
// types of the character string interpreter
// assumes nothing of its surroundings
`default_nettype none
package csi_pkg;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        CSI_IDLE,
        CSI_FETCH,
        CSI_WAIT,
        CSI_OFFER,
        CSI_CALL,
        CSI_STEP
    } csi_state_e;

    typedef logic [35:0] csi_word_t;
    typedef logic [17:0] csi_addr_t;

endpackage : csi_pkg
`default_nettype wire

// [src/csi_fifo.sv]
// flip-flop FIFO with valid/ready on both sides
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module csi_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // handshakes follow the fill count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_q[rd_q];

    // storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : csi_fifo
`default_nettype wire

// [bench/csi_core_props.sv]
// checker of the string interpreter's ports, bound into csi_core
// assumes the core's port names; the table origin is shadowed here
`timescale 1ns/1ps
`default_nettype none
`include "csi_cfg.svh"
module csi_core_props (
    // clock, reset and register port
    input wire logic               core_clk,
    input wire logic               srst,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [3:0]         reg_index,
    input wire csi_pkg::csi_word_t reg_wdata,
    input wire logic               reg_rvalid,
    input wire csi_pkg::csi_word_t reg_rdata,
    // controller and memory
    input wire logic               do_char,
    input wire csi_pkg::csi_addr_t read_pointer,
    input wire logic               prog_stop,
    input wire logic               repeat_mode,
    input wire logic               dispatch_load,
    input wire csi_pkg::csi_addr_t dispatch_pointer,
    input wire logic               mem_req,
    input wire csi_pkg::csi_addr_t mem_addr,
    input wire logic               mem_gnt,
    // glyph generator
    input wire logic               gen_valid,
    input wire logic [7:0]         gen_code,
    input wire logic               gen_hit,
    input wire logic               gen_enabled
);
    import csi_pkg::*;
    csi_addr_t org_q;
    logic      fmt_wr;
    logic      unmapped;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // ********
    // helpers
    // ********
    // decode of register accesses
    assign fmt_wr   = reg_wr && reg_index == `CSI_REG_FORMAT;
    assign unmapped = !(reg_index inside {`CSI_REG_PACKED,
                        `CSI_REG_FORMAT, `CSI_REG_UPCOMING});
    // shadow of the table origin
    always_ff @(posedge core_clk) begin
        org_q <= srst ? '0 : fmt_wr ? reg_wdata[17:0] : org_q;
    end
    // generator state after a pair write
    function automatic logic pair_next(input logic [1:0] pr,
                                       input logic cur);
        pair_next = pr == 2'b10 ? 1'b1 : pr == 2'b01 ? 1'b0 :
                    pr == 2'b11 ? !cur : cur;
    endfunction : pair_next
    // ********
    // assertions
    // ********
    chk_start_fetch: assert property (
        !repeat_mode && do_char |=> repeat_mode && mem_req)
        else $error("start did not raise a fetch");
    chk_req_hold: assert property (
        mem_req && !mem_gnt |=> mem_req ##0 mem_addr == read_pointer)
        else $error("fetch request dropped or misaddressed");
    chk_disp_addr: assert property (
        dispatch_load |-> dispatch_pointer == org_q + 18'($past(gen_code)))
        else $error("dispatch address is not origin plus code");
    chk_gen_gate: assert property (
        gen_valid |-> gen_enabled)
        else $error("code offered to a disabled generator");
    chk_hit_skip: assert property (
        gen_valid && gen_hit |=> !dispatch_load)
        else $error("accepted code was dispatched");
    chk_miss_disp: assert property (
        gen_valid && !gen_hit |=> dispatch_load)
        else $error("rejected code was not dispatched");
    chk_ptr_hold: assert property (
        !dispatch_load |-> $stable(dispatch_pointer))
        else $error("dispatch pointer moved without a dispatch");
    chk_pair_code: assert property (
        fmt_wr |=> gen_enabled ==
        pair_next($past(reg_wdata[20:19]), $past(gen_enabled)))
        else $error("generator state wrong after pair write");
    chk_rd_answer: assert property (
        reg_rd |=> reg_rvalid ##0 (!$past(unmapped) || reg_rdata == '0))
        else $error("read answer missing or unmapped not zero");
    chk_fmt_read: assert property (
        reg_rd && reg_index == `CSI_REG_FORMAT |=>
        reg_rdata[21] && reg_rdata[20:19] == 2'b00)
        else $error("format read shows wrong enable or pair bits");
    chk_prog_stop: assert property (
        repeat_mode && prog_stop |-> ##[1:2] !repeat_mode)
        else $error("program mode entry did not stop");
    cov_dispatch: cover property (dispatch_load);
    cov_hit: cover property (gen_valid && gen_hit);
    cov_stop: cover property (repeat_mode && prog_stop);
endmodule : csi_core_props
bind csi_core csi_core_props i_csi_core_props (.*);
`default_nettype wire

// [bench/csi_ctrl_model.sv]
// channel controller model: read pointer, memory, subroutine returns
// assumes csi_core's ports; drives after the rising edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module csi_ctrl_model #(
    parameter csi_pkg::csi_addr_t STOP_ADR = 18'h00143
) (
    // clock, reset and string start
    input  wire logic               core_clk,
    input  wire logic               srst,
    input  wire logic               do_char,
    input  wire logic               repeat_mode,
    input  wire csi_pkg::csi_addr_t start_ptr,
    input  wire csi_pkg::csi_word_t img [0:3],
    // interpreter side
    output csi_pkg::csi_addr_t      read_pointer,
    input  wire logic               word_taken,
    input  wire logic               dispatch_load,
    input  wire csi_pkg::csi_addr_t dispatch_pointer,
    output logic                    sub_return,
    output logic                    prog_stop,
    // memory read port
    input  wire logic               mem_req,
    input  wire csi_pkg::csi_addr_t mem_addr,
    output logic                    mem_gnt,
    output logic                    mem_rvalid,
    input  wire logic               mem_rready,
    output csi_pkg::csi_word_t      mem_rdata
);
    import csi_pkg::*;
    logic       slow_q;
    logic       busy_q;
    logic [2:0] wait_q;
    csi_word_t  word_q;
    // grant only every second cycle; released data shows the inverse
    assign mem_gnt   = mem_req && slow_q;
    assign mem_rdata = mem_rvalid ? word_q : ~word_q;
    // pointer, memory answer and subroutine return, prompt or slow
    always_ff @(posedge core_clk) begin
        slow_q     <= !srst && !slow_q;
        sub_return <= 1'b0;
        prog_stop  <= 1'b0;
        if (srst) begin
            read_pointer <= '0;
            mem_rvalid   <= 1'b0;
            busy_q       <= 1'b0;
            wait_q       <= 3'h0;
        end else begin
            if (do_char && !repeat_mode) begin
                read_pointer <= start_ptr;
            end else if (word_taken) begin
                read_pointer <= read_pointer + 18'h1;
            end
            if (word_taken) begin
                mem_rvalid <= 1'b1;
                word_q     <= img[mem_addr[1:0]];
            end else if (mem_rready) begin
                mem_rvalid <= 1'b0;
            end
            if (dispatch_load) begin
                busy_q <= 1'b1;
                wait_q <= slow_q ? 3'h1 : 3'h4;
            end else if (busy_q && wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end else if (busy_q) begin
                busy_q     <= 1'b0;
                sub_return <= dispatch_pointer != STOP_ADR;
                prog_stop  <= dispatch_pointer == STOP_ADR;
            end
        end
    end
endmodule : csi_ctrl_model
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench of the character string interpreter
// assumes csi_core, the controller model and the checker compiled
`timescale 1ns/1ps
`default_nettype none
`include "csi_cfg.svh"
module testbench;
    import csi_pkg::*;
    localparam csi_addr_t ORG   = 18'h00100;
    localparam csi_word_t FMASK = 36'hFCF3BFFFF;
    logic       core_clk = 1'b0;
    logic       srst = 1'b1;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, do_char = 1'b0;
    logic       count_load = 1'b0, gen_present = 1'b0;
    logic [3:0] reg_index = 4'h0;
    logic [7:0] gen_code, hit_code = 8'h42;
    csi_word_t  reg_wdata = '0, reg_rdata, mem_rdata;
    csi_addr_t  count_value = '0, start_ptr = '0, read_pointer;
    csi_addr_t  read_count, dispatch_pointer, mem_addr;
    logic       reg_rvalid, sub_return, prog_stop, repeat_mode;
    logic       word_taken, dispatch_load, mem_req, mem_gnt;
    logic       mem_rvalid, mem_rready, gen_valid, gen_hit, gen_enabled;
    csi_addr_t  exp_q [$];
    int         failures = 0, total_checks = 0, n_disp = 0;
    logic [1:0] pairs [0:4] = '{2'b00, 2'b11, 2'b11, 2'b10, 2'b01};
    logic       on_exp [0:4] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    // codes packed high, spare bits at the low end
    csi_word_t  img [0:3] = '{{8'h41, 8'h42, 8'h44, 8'h45, 4'h0},
        {8'h46, 28'h0}, {12'hA55, 12'h3C7, 12'h0FF},
        {8'h47, 8'h43, 8'h48, 8'h49, 4'h0}};
    // design, controller model and generator that knows one code
    csi_core i_csi_core (.*);
    csi_ctrl_model i_csi_ctrl_model (.*);
    assign gen_hit = gen_valid && gen_code == hit_code;
    always #10 core_clk = ~core_clk;
    // ********
    // tasks
    // ********
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] idx, input csi_word_t d);
        @(negedge core_clk);
        reg_index = idx;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] idx, input csi_word_t e,
                      input csi_word_t m);
        @(negedge core_clk);
        reg_index = idx;
        reg_rd    = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rvalid, 1'b1);
        chk(reg_rdata & m, e & m);
    endtask : rd
    function automatic csi_word_t fmt(input logic [5:0] o,
        input logic [3:0] w, input logic e, input logic [1:0] pr);
        fmt = {o, 2'h0, w, 2'h0, e, pr, 1'h0, ORG};
    endfunction : fmt
    // load count, start, poke a second start while busy, await the end
    task automatic run(input csi_addr_t p, input int n, input int nd);
        int k;
        n_disp = 0;
        @(negedge core_clk);
        count_value = 18'(-n);
        count_load  = 1'b1;
        start_ptr   = p;
        @(negedge core_clk);
        count_load = 1'b0;
        do_char    = 1'b1;
        for (k = 0; k < 3000 && (k == 0 || repeat_mode === 1'b1); k++) begin
            @(negedge core_clk);
            do_char = k == 6;
        end
        do_char = 1'b0;
        chk(repeat_mode, 1'b0);
        chk(n_disp, nd);
        chk(exp_q.size(), 0);
        chk(mem_rready, 1'b1);
    endtask : run
    task automatic wrap_up;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // every dispatch is compared with the next expected address
    always @(negedge core_clk) begin
        if (dispatch_load === 1'b1) begin
            n_disp++;
            chk(dispatch_pointer, exp_q.size() ? exp_q.pop_front() : '1);
        end
    end
    // watchdog
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    // ********
    // tests
    // ********
    initial begin
        repeat (12) @(negedge core_clk);
        srst = 1'b0;
        wr(1, fmt(6'd28, 4'd8, 1'b1, 2'b00));
        rd(1, fmt(6'd28, 4'd8, 1'b1, 2'b00), FMASK);
        wr(1, fmt(6'd5, 4'd3, 1'b0, 2'b00));
        rd(1, fmt(6'd28, 4'd8, 1'b1, 2'b00), FMASK);
        rd(4'h7, '0, '1);
        wr(0, img[0]);
        rd(0, img[0], '1);
        rd(4'hF, 36'h41, '1);
        wr(4'hF, '0);
        rd(4'hF, 36'h42, '1);
        // two words, no generator fitted, offset self-initialises
        wr(1, fmt(6'h3F, 4'd8, 1'b1, 2'b00));
        exp_q = {ORG + 18'h41, ORG + 18'h42, ORG + 18'h44, ORG + 18'h45,
                 ORG + 18'h46};
        run(0, 5, 5);
        chk(read_count, 18'h0);
        // generator on: the accepted code is not dispatched
        gen_present = 1'b1;
        wr(1, fmt(6'h3F, 4'd8, 1'b1, 2'b10));
        chk(gen_enabled, 1'b1);
        exp_q = {ORG + 18'h41, ORG + 18'h44, ORG + 18'h45, ORG + 18'h46};
        run(0, 5, 4);
        foreach (pairs[i]) begin
            wr(1, fmt(6'h3F, 4'd8, 1'b1, pairs[i]));
            chk(gen_enabled, on_exp[i]);
        end
        // wide codes: only the low eight bits reach the address
        wr(1, fmt(6'h3F, 4'hC, 1'b1, 2'b00));
        exp_q = {ORG + 18'h55, ORG + 18'hC7, ORG + 18'hFF};
        run(2, 3, 3);
        // a table entry that returns to program mode ends the string
        wr(1, fmt(6'h3F, 4'd8, 1'b1, 2'b00));
        exp_q = {ORG + 18'h47, ORG + 18'h43};
        run(3, 4, 2);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
